/* rtl/mpbc_pkg.sv */
// Function
// - Boot on power-up and on any reset
// - Send ready banner after boot in command mode
// - Low reset pin resets; host drives open-drain
// - Soft-reset command reboots the device
// - Switch ACTIVE and STANDBY automatically by activity
// - STANDBY keeps links, returns to ACTIVE at once
// - Clock scaling lowers clocks outside ACTIVE, caps baud 1M
// - SLEEP withholds serial output; data may drop
// - After sleep command, each DSR toggle switches SLEEP
// - SLEEP allowed only as station or radio off
// - STOP halts all, drops state, wakes by reboot
// - After stop command, each DSR toggle switches STOP
// - Configured GPIO activity enters or leaves STOP
// - Wake timer ends STOP after chosen delay
// - Boot-mode strap: 0 factory, 1 normal boot
// - Print strap: 0 silent, 1 boot info
// - Flash supply strap must read 1 for 1.8V
// - After boot detect command interface from lines
// - No power-down input; STOP is deepest state
// - Host leaves bootstrap pins undriven at boot
package mpbc_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int BOOT_TIME_US = 20;
  localparam int BOOT_CYCLES = BOOT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int WAKE_UNIT_MS = 1;
  localparam int MS_CYCLES = WAKE_UNIT_MS * (CLK_HZ / 1000);
  localparam int DRDY_HALF_US = 1;
  localparam int DRDY_HALF_CYCLES = DRDY_HALF_US * (CLK_HZ / 1_000_000);
  localparam logic [3:0] SPI_DETECT_EDGES = 4'h8;
  localparam int BAUD_CAP = 1_000_000;
  localparam int CMD_W = 4;
  localparam int ARG_W = 16;
  localparam logic [CMD_W-1:0] CMD_SOFT_RESET = 4'h1;
  localparam logic [CMD_W-1:0] CMD_SLEEP_PIN = 4'h2;
  localparam logic [CMD_W-1:0] CMD_STOP_PIN = 4'h3;
  localparam logic [CMD_W-1:0] CMD_STOP_CFG = 4'h4;
  localparam logic [CMD_W-1:0] CMD_PWR_MGMT = 4'h5;
  localparam int STOP_CFG_TIMER_BIT = 15;
  localparam int STOP_CFG_GPIO_EN_BIT = 14;
  localparam int STRAP_BOOT = 0;
  localparam int STRAP_PRINT = 1;
  localparam int STRAP_FLASH = 2;
  localparam logic [7:0] BOOT_INFO_BYTE = 8'h5a;
  localparam int AXI_AW = 5;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_CMD = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_LINES = 2'h3;
  localparam logic [2:0] LINES_RESET = 3'h2;
  localparam int CMD_CODE_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0, ST_DETECT = 3'h1, ST_ACTIVE = 3'h3,
    ST_STANDBY = 3'h2, ST_SLEEP = 3'h6, ST_STOP = 3'h7
  } mpbc_mode_type;
  typedef enum logic [1:0] {
    IF_NONE = 2'h0, IF_UART = 2'h1, IF_ETH = 2'h2, IF_SPI = 2'h3
  } mpbc_if_type;
endpackage

/* rtl/mpbc_link.sv */
interface mpbc_link;
  import mpbc_pkg::*;
  logic rst_out;
  logic rst_oe_n;
  logic rst_n;
  logic [2:0] strap_out;
  logic [2:0] strap_oe_n;
  logic [2:0] strap;
  logic dsr;
  logic eth_clk;
  logic uart_rxd;
  logic spi_sclk;
  logic data_ready_pin;
  logic cmd_valid;
  logic cmd_ready;
  logic [CMD_W-1:0] cmd_code;
  logic [ARG_W-1:0] cmd_arg;
  logic tx_valid;
  logic [7:0] tx_data;
  logic banner;
  // Pull-ups win wherever nobody drives
  assign rst_n = rst_oe_n | rst_out;
  assign strap = strap_oe_n | strap_out;
  modport dev(input rst_n, strap, dsr, eth_clk, uart_rxd, spi_sclk, cmd_valid, cmd_code,
    cmd_arg, output cmd_ready, tx_valid, tx_data, banner, data_ready_pin);
  modport host(output rst_out, rst_oe_n, strap_out, strap_oe_n, dsr, eth_clk, uart_rxd,
    spi_sclk, cmd_valid, cmd_code, cmd_arg, input rst_n, cmd_ready, tx_valid, tx_data,
    banner, data_ready_pin);
endinterface

/* rtl/mpbc_device.sv */
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
module mpbc_device #(
  parameter int MS_TICKS = mpbc_pkg::MS_CYCLES
) (
  // Clock and power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link to host
  mpbc_link.dev link,
  // Device side
  input wire logic activity,
  input wire logic radio_sleep_ok,
  input wire logic cmd_mode_start,
  input wire logic [3:0] stop_gpio,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output mpbc_pkg::mpbc_mode_type power_mode,
  output mpbc_pkg::mpbc_if_type iface,
  output logic cpu_full_speed,
  output logic clk_scaled,
  output logic baud_cap_1m,
  output logic factory_boot,
  output logic print_en,
  output logic flash_1v8
);
  import mpbc_pkg::*;

  typedef struct packed {
    mpbc_mode_type mode;
    logic [9:0] boot_cnt;
    logic factory_boot;
    logic print_en;
    logic flash_1v8;
    mpbc_if_type iface;
    logic drdy;
    logic [5:0] drdy_cnt;
    logic [3:0] sclk_cnt;
    logic prev_eth;
    logic prev_rxd;
    logic prev_sclk;
    logic prev_dsr;
    logic prev_gpio;
    logic sleep_pin_en;
    logic stop_pin_en;
    logic stop_gpio_en;
    logic [1:0] stop_gpio_sel;
    logic timer_en;
    logic [14:0] timer_ms;
    logic [15:0] ms_cnt;
    logic [14:0] stop_left;
    logic clk_scale_en;
    logic banner;
    logic tx_valid;
    logic [7:0] tx_data;
  } mpbc_dev_type;

  mpbc_dev_type s;
  mpbc_dev_type next_s;
  logic cmd_ready;
  logic cmd_take;
  logic dsr_tog;
  logic gpio_tog;
  logic rxd_fall;
  logic sclk_rise;
  logic ms_tick;
  logic go_stop;
  logic run;

  assign run = (s.mode == ST_ACTIVE) || (s.mode == ST_STANDBY);
  assign cmd_ready = run && link.rst_n;
  assign link.cmd_ready = cmd_ready;
  assign link.tx_valid = s.tx_valid;
  assign link.tx_data = s.tx_data;
  assign link.banner = s.banner;
  assign link.data_ready_pin = s.drdy;
  assign power_mode = s.mode;
  assign iface = s.iface;
  assign cpu_full_speed = (s.mode == ST_ACTIVE);
  assign clk_scaled = s.clk_scale_en && (s.mode != ST_ACTIVE);
  assign baud_cap_1m = s.clk_scale_en;
  assign factory_boot = s.factory_boot;
  assign print_en = s.print_en;
  assign flash_1v8 = s.flash_1v8;

  always_comb begin
    next_s = s;
    next_s.banner = 1'b0;
    next_s.tx_valid = 1'b0;
    cmd_take = link.cmd_valid && cmd_ready;
    dsr_tog = link.dsr ^ s.prev_dsr;
    gpio_tog = s.stop_gpio_en && (stop_gpio[s.stop_gpio_sel] ^ s.prev_gpio);
    rxd_fall = s.prev_rxd && !link.uart_rxd;
    sclk_rise = !s.prev_sclk && link.spi_sclk;
    ms_tick = (s.ms_cnt == 16'(MS_TICKS - 1));
    go_stop = (s.stop_pin_en && dsr_tog) || gpio_tog;
    next_s.prev_eth = link.eth_clk;
    next_s.prev_rxd = link.uart_rxd;
    next_s.prev_sclk = link.spi_sclk;
    next_s.prev_dsr = link.dsr;
    next_s.prev_gpio = stop_gpio[s.stop_gpio_sel];
    unique case (s.mode)
      ST_BOOT: begin
        next_s.iface = IF_NONE;
        next_s.drdy = 1'b0;
        if (s.boot_cnt == 10'(BOOT_CYCLES - 1)) begin
          next_s.factory_boot = !link.strap[STRAP_BOOT];
          next_s.print_en = link.strap[STRAP_PRINT];
          next_s.flash_1v8 = link.strap[STRAP_FLASH];
          next_s.tx_valid = link.strap[STRAP_PRINT];
          next_s.tx_data = BOOT_INFO_BYTE;
          next_s.sclk_cnt = 4'h0;
          next_s.drdy_cnt = 6'h0;
          next_s.mode = ST_DETECT;
        end else begin
          next_s.boot_cnt = s.boot_cnt + 10'h1;
        end
      end
      ST_DETECT: begin
        // Data-ready pin toggles to invite a serial-peripheral master
        if (s.drdy_cnt == 6'(DRDY_HALF_CYCLES - 1)) begin
          next_s.drdy_cnt = 6'h0;
          next_s.drdy = !s.drdy;
        end else begin
          next_s.drdy_cnt = s.drdy_cnt + 6'h1;
        end
        if (sclk_rise) begin
          next_s.sclk_cnt = s.sclk_cnt + 4'h1;
        end
        if (link.eth_clk ^ s.prev_eth) begin
          next_s.iface = IF_ETH;
        end else if (sclk_rise && (s.sclk_cnt == SPI_DETECT_EDGES - 4'h1)) begin
          next_s.iface = IF_SPI;
        end else if (rxd_fall) begin
          next_s.iface = IF_UART;
        end
        if (next_s.iface != IF_NONE) begin
          next_s.mode = ST_ACTIVE;
          next_s.drdy = 1'b0;
          next_s.banner = cmd_mode_start;
        end
      end
      ST_ACTIVE, ST_STANDBY: begin
        next_s.mode = activity ? ST_ACTIVE : ST_STANDBY;
        next_s.tx_valid = in_valid;
        next_s.tx_data = in_data;
        if ((s.iface == IF_SPI) && rxd_fall) begin
          next_s.iface = IF_UART;
        end
        if (cmd_take) begin
          unique case (link.cmd_code)
            CMD_SLEEP_PIN: next_s.sleep_pin_en = link.cmd_arg[0];
            CMD_STOP_PIN: next_s.stop_pin_en = link.cmd_arg[0];
            CMD_PWR_MGMT: next_s.clk_scale_en = link.cmd_arg[0];
            CMD_STOP_CFG: begin
              if (link.cmd_arg[STOP_CFG_TIMER_BIT]) begin
                next_s.timer_en = 1'b1;
                next_s.timer_ms = link.cmd_arg[14:0];
              end else begin
                next_s.stop_gpio_en = link.cmd_arg[STOP_CFG_GPIO_EN_BIT];
                next_s.stop_gpio_sel = link.cmd_arg[1:0];
                next_s.timer_en = 1'b0;
              end
            end
            default: ;
          endcase
        end
        if (go_stop) begin
          // Deepest state; there is no separate power-down input
          next_s.mode = ST_STOP;
          next_s.iface = IF_NONE;
          next_s.tx_valid = 1'b0;
          next_s.ms_cnt = 16'h0;
          next_s.stop_left = s.timer_ms;
        end else if (s.sleep_pin_en && dsr_tog && radio_sleep_ok) begin
          next_s.mode = ST_SLEEP;
          next_s.tx_valid = 1'b0;
        end
      end
      ST_SLEEP: begin
        // Incoming data is dropped, never queued
        next_s.tx_valid = 1'b0;
        if (dsr_tog) begin
          next_s.mode = activity ? ST_ACTIVE : ST_STANDBY;
        end
      end
      ST_STOP: begin
        next_s.ms_cnt = ms_tick ? 16'h0 : s.ms_cnt + 16'h1;
        if (ms_tick && (s.stop_left != 15'h0)) begin
          next_s.stop_left = s.stop_left - 15'h1;
        end
        if (go_stop || (s.timer_en && ms_tick && (s.stop_left <= 15'h1))) begin
          next_s.mode = ST_BOOT;
          next_s.boot_cnt = 10'h0;
        end
      end
      default: begin
        next_s.mode = ST_BOOT;
        next_s.boot_cnt = 10'h0;
      end
    endcase
    if (!link.rst_n || (cmd_take && (link.cmd_code == CMD_SOFT_RESET))) begin
      next_s.mode = ST_BOOT;
      next_s.boot_cnt = 10'h0;
      next_s.iface = IF_NONE;
      next_s.tx_valid = 1'b0;
      next_s.banner = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.mode <= ST_BOOT;
      s.prev_rxd <= 1'b1;
      s.prev_dsr <= 1'b0;
    end else begin
      s <= next_s;
    end
  end
endmodule

/* rtl/mpbc_host.sv */
module mpbc_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [mpbc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [mpbc_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Link to device
  mpbc_link.host link
);
  import mpbc_pkg::*;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rst_assert;
    logic dsr;
    logic [2:0] lines;
    logic pin_ctl_ok;
    logic cmd_valid;
    logic [CMD_W-1:0] cmd_code;
    logic [ARG_W-1:0] cmd_arg;
    logic [7:0] banner_cnt;
    logic [7:0] rx_byte;
    logic [7:0] rx_cnt;
  } mpbc_host_type;

  mpbc_host_type s;
  mpbc_host_type next_s;
  logic [31:0] wmask;
  logic [31:0] status;

  assign s_axi_awready = !s.aw_held;
  assign s_axi_wready = !s.w_held;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign link.rst_out = 1'b0;
  assign link.rst_oe_n = !s.rst_assert;
  assign link.strap_out = 3'h0;
  assign link.strap_oe_n = 3'h7;
  assign link.dsr = s.dsr;
  assign link.eth_clk = s.lines[0];
  assign link.uart_rxd = s.lines[1];
  assign link.spi_sclk = s.lines[2];
  assign link.cmd_valid = s.cmd_valid;
  assign link.cmd_code = s.cmd_code;
  assign link.cmd_arg = s.cmd_arg;

  always_comb begin
    next_s = s;
    wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
    status = {s.rx_cnt, s.rx_byte, s.banner_cnt, 4'h0, link.rst_n, link.data_ready_pin,
      s.pin_ctl_ok, s.cmd_valid};
    if (s.cmd_valid && link.cmd_ready) begin
      next_s.cmd_valid = 1'b0;
      if ((s.cmd_code == CMD_SLEEP_PIN) || (s.cmd_code == CMD_STOP_PIN)) begin
        next_s.pin_ctl_ok = s.cmd_arg[0];
      end
    end
    if (link.banner) begin
      next_s.banner_cnt = s.banner_cnt + 8'h1;
    end
    if (link.tx_valid) begin
      next_s.rx_byte = link.tx_data;
      next_s.rx_cnt = s.rx_cnt + 8'h1;
    end
    if (s_axi_awvalid && !s.aw_held) begin
      next_s.awaddr = s_axi_awaddr;
      next_s.aw_held = 1'b1;
    end
    if (s_axi_wvalid && !s.w_held) begin
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
      next_s.w_held = 1'b1;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s.awaddr[AXI_AW-1]) begin
        next_s.bresp = RESP_SLVERR;
      end else begin
        unique case (s.awaddr[3:2])
          REG_CTRL: begin
            if (s.wstrb[0]) begin
              next_s.rst_assert = s.wdata[0];
              if (s.wdata[1] && s.pin_ctl_ok) begin
                next_s.dsr = !s.dsr;
              end
            end
          end
          REG_CMD: begin
            if (s.cmd_valid) begin
              next_s.bresp = RESP_SLVERR;
            end else begin
              next_s.cmd_valid = 1'b1;
              next_s.cmd_arg = (s.cmd_arg & wmask[15:0]) ^ s.cmd_arg ^
                (s.wdata[15:0] & wmask[15:0]) ^ (s.cmd_arg & wmask[15:0]) ^
                (s.cmd_arg & wmask[15:0]);
              next_s.cmd_code = s.wstrb[2] ? s.wdata[CMD_CODE_LSB+:CMD_W] : s.cmd_code;
            end
          end
          REG_LINES: begin
            if (s.wstrb[0]) begin
              next_s.lines = s.wdata[2:0];
            end
          end
          REG_STATUS: ;
        endcase
      end
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0;
      if (s_axi_araddr[AXI_AW-1]) begin
        next_s.rresp = RESP_SLVERR;
      end else begin
        unique case (s_axi_araddr[3:2])
          REG_CTRL: next_s.rdata = {31'h0, s.rst_assert};
          REG_CMD: next_s.rdata = {12'h0, s.cmd_code, s.cmd_arg};
          REG_STATUS: next_s.rdata = status;
          REG_LINES: next_s.rdata = {29'h0, s.lines};
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.lines <= LINES_RESET;
    end else begin
      s <= next_s;
    end
  end
endmodule

/* verif/mpbc_asserts.sv */
module mpbc_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset and strap lines
  input wire logic rst_out,
  input wire logic rst_oe_n,
  input wire logic rst_n,
  input wire logic [2:0] strap_oe_n,
  input wire logic [2:0] strap,
  // Command link
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [mpbc_pkg::CMD_W-1:0] cmd_code,
  input wire logic [mpbc_pkg::ARG_W-1:0] cmd_arg,
  // Device status lines
  input wire logic banner,
  input wire logic data_ready_pin
);
  import mpbc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Command handed over
  sequence s_taken;
    cmd_valid && cmd_ready;
  endsequence
  // Device busy rebooting
  sequence s_booting;
    !cmd_ready [*8];
  endsequence
  chk_reset_blocks_cmd: assert property (!rst_n |-> !cmd_ready)
    else $error("command accepted while reset line low");
  chk_rst_open_drain: assert property (!rst_oe_n |-> !rst_out)
    else $error("reset line driven high");
  chk_straps_free: assert property (strap_oe_n == 3'h7 && strap == 3'h7)
    else $error("strap lines driven");
  chk_flash_strap: assert property (strap[2])
    else $error("flash supply strap low");
  chk_cmd_held: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_code) && $stable(cmd_arg))
    else $error("pending command changed");
  chk_cmd_drop: assert property (s_taken |=> !cmd_valid)
    else $error("command valid kept after take");
  chk_soft_reboot: assert property (s_taken ##0 cmd_code == CMD_SOFT_RESET |-> ##2 s_booting)
    else $error("no reboot after soft reset command");
  chk_banner_pulse: assert property (banner |=> !banner)
    else $error("banner longer than one cycle");
  chk_banner_ready: assert property (banner |-> ##[0:1] cmd_ready)
    else $error("banner without command readiness");
  chk_drdy_quiet: assert property (cmd_ready ##1 cmd_ready |-> $stable(data_ready_pin))
    else $error("data ready toggles after detection");
  chk_drdy_period: assert property ($rose(data_ready_pin) |=> data_ready_pin [*8])
    else $error("data ready half period too short");
  chk_boot_restart: assert property (!rst_n ##1 rst_n |-> s_booting)
    else $error("no boot after reset line release");
endmodule

/* verif/mpbc_bench.sv */
module mpbc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mpbc_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} mpbc_exp_type;
  localparam int MS = 4;
  localparam logic [4:0] A_CTRL = {1'b0, REG_CTRL, 2'h0};
  localparam logic [4:0] A_CMD = {1'b0, REG_CMD, 2'h0};
  localparam logic [4:0] A_STAT = {1'b0, REG_STATUS, 2'h0};
  localparam logic [4:0] A_LINE = {1'b0, REG_LINES, 2'h0};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, activity, sleep_ok, cmd_start, in_valid;
  logic full_speed, scaled, baud_cap, factory, print, flash, a;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, gpio;
  logic [1:0] bresp, rresp;
  logic [7:0] in_data;
  mpbc_mode_type mode;
  mpbc_if_type iface;
  int n_fail, comparisons, seed, n_info, i;
  logic [1:0] bq[$];
  mpbc_exp_type rq[$];
  logic [7:0] tq[$];
  mpbc_exp_type e;
  mpbc_link link();
  mpbc_device #(.MS_TICKS(MS)) u_mpbc_device(.aclk(aclk), .aresetn(aresetn), .link(link),
    .activity(activity), .radio_sleep_ok(sleep_ok), .cmd_mode_start(cmd_start),
    .stop_gpio(gpio), .in_valid(in_valid), .in_data(in_data), .power_mode(mode),
    .iface(iface), .cpu_full_speed(full_speed), .clk_scaled(scaled), .baud_cap_1m(baud_cap),
    .factory_boot(factory), .print_en(print), .flash_1v8(flash));
  mpbc_host u_mpbc_host(.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .link(link));
  mpbc_asserts u_mpbc_asserts(.aclk(aclk), .aresetn(aresetn), .rst_out(link.rst_out),
    .rst_oe_n(link.rst_oe_n), .rst_n(link.rst_n), .strap_oe_n(link.strap_oe_n),
    .strap(link.strap), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
    .cmd_code(link.cmd_code), .cmd_arg(link.cmd_arg), .banner(link.banner),
    .data_ready_pin(link.data_ready_pin));
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [4:0] ad, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) begin
      $display("Error at %0t: write response timeout", $time);
      n_fail++;
      test_done;
    end
  endtask
  task automatic axi_rd(input logic [4:0] ad, input logic [31:0] d, input logic [31:0] m,
    input logic [1:0] r);
    int n;
    @(posedge aclk);
    rq.push_back(mpbc_exp_type'{d, m, r});
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 100) begin
      $display("Error at %0t: read response timeout", $time);
      n_fail++;
      test_done;
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [15:0] g);
    axi_wr(A_CMD, {12'h0, c, g}, RESP_OKAY);
    repeat (4) @(posedge aclk);
  endtask
  task automatic wait_mode(input mpbc_mode_type m);
    int n;
    for (n = 0; n < 2000 && mode !== m; n++) @(posedge aclk);
    check(32'(mode), 32'(m));
    if (n == 2000) test_done;
  endtask
  task automatic send(input logic fwd);
    logic [7:0] d;
    @(posedge aclk);
    d = 8'h80 | 8'($random(seed));
    in_data <= d;
    in_valid <= 1'b1;
    if (fwd) tq.push_back(d);
    @(posedge aclk);
    in_valid <= 1'b0;
  endtask
  // Response and byte monitor
  always @(posedge aclk) begin
    if (bvalid && bready) check({30'h0, bresp}, {30'h0, bq.pop_front()});
    if (rvalid && rready) begin
      e = rq.pop_front();
      check(rdata & e.m, e.d & e.m);
      check({30'h0, rresp}, {30'h0, e.r});
    end
    if (link.tx_valid && link.tx_data === BOOT_INFO_BYTE) n_info++;
    else if (link.tx_valid)
      check({24'h0, link.tx_data}, (tq.size() > 0) ? {24'h0, tq.pop_front()} : 32'h100);
  end
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, activity, sleep_ok, in_valid} = '0;
    {awaddr, araddr, wdata, in_data, gpio} = '0;
    wstrb = 4'hf;
    cmd_start = 1'b1;
    seed = 32'hd297f2d0;
    {n_fail, comparisons, n_info} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wait_mode(ST_DETECT);
    check({29'h0, factory, print, flash}, 32'h3);
    // Data-ready pin is high in the second half period of detection
    repeat (50) @(posedge aclk);
    axi_rd(A_STAT, 32'h4, 32'h4, RESP_OKAY);
    check(32'(n_info), 32'h1);
    axi_wr(A_LINE, 32'h3, RESP_OKAY);
    wait_mode(ST_STANDBY);
    check(32'(iface), 32'(IF_ETH));
    axi_wr(5'h10, 32'h1, RESP_SLVERR);
    axi_rd(5'h14, 32'h0, 32'hffffffff, RESP_SLVERR);
    axi_rd(A_STAT, 32'h108, 32'hff0b, RESP_OKAY);
    cmd(CMD_PWR_MGMT, 16'h1);
    repeat (6) begin
      a = 1'($random(seed));
      activity <= a;
      repeat (3) @(posedge aclk);
      check({26'h0, baud_cap, scaled, full_speed, mode},
        {26'h0, 1'b1, !a, a, a ? ST_ACTIVE : ST_STANDBY});
      send(1'b1);
    end
    activity <= 1'b0;
    sleep_ok <= 1'b1;
    cmd(CMD_SLEEP_PIN, 16'h1);
    axi_wr(A_CTRL, 32'h2, RESP_OKAY);
    wait_mode(ST_SLEEP);
    send(1'b0);
    axi_wr(A_CMD, {12'h0, CMD_PWR_MGMT, 16'h1}, RESP_OKAY);
    axi_wr(A_CMD, {12'h0, CMD_PWR_MGMT, 16'h1}, RESP_SLVERR);
    axi_rd(A_STAT, 32'h1, 32'h1, RESP_OKAY);
    axi_wr(A_CTRL, 32'h2, RESP_OKAY);
    wait_mode(ST_STANDBY);
    sleep_ok <= 1'b0;
    axi_wr(A_CTRL, 32'h2, RESP_OKAY);
    repeat (4) @(posedge aclk);
    check(32'(mode), 32'(ST_STANDBY));
    cmd(CMD_STOP_PIN, 16'h1);
    axi_wr(A_CTRL, 32'h2, RESP_OKAY);
    wait_mode(ST_STOP);
    send(1'b0);
    axi_wr(A_CTRL, 32'h2, RESP_OKAY);
    wait_mode(ST_BOOT);
    wait_mode(ST_DETECT);
    axi_wr(A_LINE, 32'h2, RESP_OKAY);
    wait_mode(ST_STANDBY);
    axi_rd(A_STAT, 32'h20a, 32'hff0b, RESP_OKAY);
    cmd(CMD_STOP_CFG, 16'h4002);
    axi_wr(A_CTRL, 32'h2, RESP_OKAY);
    wait_mode(ST_STOP);
    gpio <= 4'h1;
    repeat (8) @(posedge aclk);
    check(32'(mode), 32'(ST_STOP));
    gpio <= 4'h5;
    wait_mode(ST_BOOT);
    wait_mode(ST_DETECT);
    for (i = 0; i < 8; i++) begin
      axi_wr(A_LINE, 32'h6, RESP_OKAY);
      axi_wr(A_LINE, 32'h2, RESP_OKAY);
    end
    wait_mode(ST_STANDBY);
    check(32'(iface), 32'(IF_SPI));
    axi_wr(A_LINE, 32'h0, RESP_OKAY);
    repeat (4) @(posedge aclk);
    check(32'(iface), 32'(IF_UART));
    cmd(CMD_STOP_CFG, 16'h8003);
    axi_wr(A_CTRL, 32'h2, RESP_OKAY);
    wait_mode(ST_STOP);
    repeat (3 * MS - 2) @(posedge aclk);
    check(32'(mode), 32'(ST_STOP));
    repeat (2) @(posedge aclk);
    check(32'(mode), 32'(ST_BOOT));
    wait_mode(ST_DETECT);
    axi_wr(A_LINE, 32'h1, RESP_OKAY);
    wait_mode(ST_STANDBY);
    cmd(CMD_SOFT_RESET, 16'h0);
    check(32'(mode), 32'(ST_BOOT));
    axi_wr(A_CTRL, 32'h1, RESP_OKAY);
    axi_rd(A_STAT, 32'h0, 32'h8, RESP_OKAY);
    axi_wr(A_CTRL, 32'h0, RESP_OKAY);
    wait_mode(ST_DETECT);
    test_done;
  end
endmodule
